// file: mhbe_seq.sv
`timescale 1ns/10ps
`default_nettype none
module mhbe_seq
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Command side
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic        cmd_ext,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  // Peripheral bus pins
  output logic [7:0]       ad_out,
  output logic             ad_oe_n,
  input  wire logic [7:0]  ad_in,
  output logic [7:0]       addr_hi,
  output logic             ale,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  input  wire logic        wait_ready,
  output logic             bus_clock_out
);
  import mhbe_pkg::*;

  // ========================================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ========================================================================
  // Bus clock
  logic bclk_r;
  logic rise_stb;
  logic fall_stb;

  mhbe_clkdiv u_clkdiv (
    .clock    (clock),
    .rst_n    (rst_sync_n),
    .clk_en   (clk_en),
    .bclk_r   (bclk_r),
    .rise_stb (rise_stb),
    .fall_stb (fall_stb)
  );

  // Divided system clock keeps period and halves in range while clk_en is high and holds its level while clk_en is low
  assign bus_clock_out = bclk_r;

  // ========================================================================
  // Phase timing
  mhbe_state_t         state_r;
  mhbe_state_t         state_nxt;
  logic                timed;
  logic [PH_CNT_W-1:0] ph_max;
  logic                phase_end;
  logic                write_r;
  logic                ext_r;
  logic [15:0]         addr_r;
  logic [7:0]          wdata_r;
  logic                first_ale_r;

  always_comb
  begin
    timed  = 1'b1;
    ph_max = PH_NOMINAL;
    unique case (state_r)
      MHBE_ALE_HI    : ph_max = ALE_MAX;
      MHBE_RD_SELECT : ph_max = RD_SEL_MAX;
      MHBE_WR_STROBE : ph_max = WR_STROBE_MAX;
      MHBE_RD_STROBE : ph_max = RD_SETUP_MAX;
      MHBE_ADDR_HI,
      MHBE_ADDR_LO,
      MHBE_WR_SETUP  : ph_max = PH_NOMINAL;
      MHBE_IDLE,
      MHBE_ARM,
      MHBE_WR_HOLD,
      MHBE_RD_HOLD   : timed = 1'b0;
      default        : timed = 1'b0;
    endcase
  end

  // Fixed one-period phases never look at wait_ready
  mhbe_phase_timer u_timer (
    .clock      (clock),
    .rst_n      (rst_sync_n),
    .step       (rise_stb),
    .run        (timed),
    .wait_ready (wait_ready),
    .nominal    (PH_NOMINAL),
    .max_len    (ph_max),
    .phase_end  (phase_end)
  );

  // ========================================================================
  // Command capture
  logic take;

  assign take = clk_en && cmd_valid && cmd_ready && (state_r == MHBE_IDLE);

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      write_r <= 1'b0;
      ext_r   <= 1'b0;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
    end
    else if (take)
    begin
      write_r <= cmd_write;
      ext_r   <= cmd_ext;
      addr_r  <= cmd_addr;
      wdata_r <= cmd_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cmd_ready <= 1'b0;
    else if (clk_en)
      cmd_ready <= (state_nxt == MHBE_IDLE);
  end

  // ========================================================================
  // Sequencer: phases move on bus clock rises, releases on bus clock falls
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      MHBE_IDLE :
        if (take)
          state_nxt = MHBE_ARM;
      MHBE_ARM :
        if (rise_stb)
          state_nxt = ext_r ? MHBE_ADDR_HI : MHBE_ADDR_LO;
      MHBE_ADDR_HI :
        if (phase_end)
          state_nxt = MHBE_ADDR_LO;
      MHBE_ADDR_LO :
        if (phase_end)
          state_nxt = MHBE_ALE_HI;
      MHBE_ALE_HI :
        if (phase_end)
          state_nxt = write_r ? MHBE_WR_SETUP : MHBE_RD_SELECT;
      MHBE_WR_SETUP :
        if (phase_end)
          state_nxt = MHBE_WR_STROBE;
      MHBE_WR_STROBE :
        if (phase_end)
          state_nxt = MHBE_WR_HOLD;
      MHBE_WR_HOLD :
        if (fall_stb)
          state_nxt = MHBE_IDLE;
      MHBE_RD_SELECT :
        if (phase_end)
          state_nxt = MHBE_RD_STROBE;
      MHBE_RD_STROBE :
        if (phase_end)
          state_nxt = MHBE_RD_HOLD;
      MHBE_RD_HOLD :
        if (fall_stb)
          state_nxt = MHBE_IDLE;
      default :
        state_nxt = MHBE_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      state_r <= MHBE_IDLE;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // ========================================================================
  // Address and data lines
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      addr_hi <= ADDR_HI_RESET;
    else if (clk_en && (state_r == MHBE_ARM) && rise_stb && ext_r)
      addr_hi <= addr_r[15:8];
  end

  // Lower address and data share the lines; peripheral latches on ale fall
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ad_out <= AD_RESET;
    else if (clk_en)
    begin
      if ((state_nxt == MHBE_ADDR_LO) && (state_r != MHBE_ADDR_LO))
        ad_out <= addr_r[7:0];
      else if ((state_r == MHBE_ALE_HI) && phase_end && write_r)
        ad_out <= wdata_r;
    end
  end

  // Bus floats through the read strobe and read hold phases
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ad_oe_n <= 1'b0;
    else if (clk_en)
    begin
      if ((state_r == MHBE_RD_SELECT) && phase_end)
        ad_oe_n <= 1'b1;
      else if ((state_r == MHBE_RD_HOLD) && fall_stb)
        ad_oe_n <= 1'b0;
    end
  end

  // ========================================================================
  // Strobes
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ale <= 1'b0;
    else if (clk_en)
    begin
      if ((state_r == MHBE_ADDR_LO) && phase_end)
        ale <= 1'b1;
      else if ((state_r == MHBE_ALE_HI) && phase_end)
        ale <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      first_ale_r <= 1'b0;
    else if (clk_en)
    begin
      if ((state_r == MHBE_ADDR_LO) && phase_end)
        first_ale_r <= 1'b1;
      else if (rise_stb)
        first_ale_r <= 1'b0;
    end
  end

  // Read select drops one period after ale rose even if ale is stretched
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cs_n <= 1'b1;
    else if (clk_en)
    begin
      if ((state_r == MHBE_ALE_HI) && rise_stb && !write_r && first_ale_r)
        cs_n <= 1'b0;
      else if ((state_r == MHBE_ALE_HI) && phase_end)
        cs_n <= 1'b0;
      else if (((state_r == MHBE_WR_HOLD) || (state_r == MHBE_RD_HOLD)) && fall_stb)
        cs_n <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      wr_n <= 1'b1;
    else if (clk_en)
    begin
      if ((state_r == MHBE_WR_SETUP) && phase_end)
        wr_n <= 1'b0;
      else if ((state_r == MHBE_WR_STROBE) && phase_end)
        wr_n <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_n <= 1'b1;
    else if (clk_en)
    begin
      if ((state_r == MHBE_RD_SELECT) && phase_end)
        rd_n <= 1'b0;
      else if ((state_r == MHBE_RD_STROBE) && phase_end)
        rd_n <= 1'b1;
    end
  end

  // ========================================================================
  // Read answer: data taken at the edge that raises the read strobe
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rsp_rdata <= 8'h00;
    else if (clk_en && (state_r == MHBE_RD_STROBE) && phase_end)
      rsp_rdata <= ad_in;
  end

  // Answer pulses when select releases, so a new command cannot overlap
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rsp_valid <= 1'b0;
    else if (clk_en)
      rsp_valid <= ((state_r == MHBE_WR_HOLD) || (state_r == MHBE_RD_HOLD)) && fall_stb;
  end

endmodule
`default_nettype wire

// file: mhbe_pkg.sv
// ==========================================================================
// Shared constants for the host bus emulation sequencer
`default_nettype none
package mhbe_pkg;

  // ========================================================================
  // Timing: system clock and emulated bus clock
  localparam int unsigned CLK_PERIOD_PS     = 50000;
  localparam int unsigned BUS_PERIOD_TYP_PS = 83300;
  localparam int unsigned BUS_PERIOD_MIN_PS = 41600;
  localparam int unsigned BUS_PERIOD_MAX_PS = 125000;
  localparam int unsigned BUS_HALF_MIN_PS   = 20800;
  localparam int unsigned BUS_HALF_MAX_PS   = 62500;
  // Half period rounded up from the least high/low time, at least one cycle
  localparam int unsigned HALF_CYC_RAW      = (BUS_HALF_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HALF_CYC          = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
  localparam int unsigned HALF_CNT_W        = 4;

  // ========================================================================
  // Phase lengths in bus clock periods: nominal and stretched by wait_ready
  localparam int unsigned PH_CNT_W      = 3;
  localparam logic [2:0]  PH_NOMINAL    = 3'h1;
  localparam logic [2:0]  ALE_MAX       = 3'h2;
  localparam logic [2:0]  RD_SEL_MAX    = 3'h3;
  localparam logic [2:0]  WR_STROBE_MAX = 3'h6;
  localparam logic [2:0]  RD_SETUP_MAX  = 3'h5;

  // ========================================================================
  // Reset values of the pins
  localparam logic [7:0]  AD_RESET      = 8'h00;
  localparam logic [7:0]  ADDR_HI_RESET = 8'h00;

  // ========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    MHBE_IDLE      = 4'h0,
    MHBE_ARM       = 4'h1,
    MHBE_ADDR_HI   = 4'h2,
    MHBE_ADDR_LO   = 4'h3,
    MHBE_ALE_HI    = 4'h4,
    MHBE_WR_SETUP  = 4'h5,
    MHBE_WR_STROBE = 4'h6,
    MHBE_WR_HOLD   = 4'h7,
    MHBE_RD_SELECT = 4'h8,
    MHBE_RD_STROBE = 4'h9,
    MHBE_RD_HOLD   = 4'hA
  } mhbe_state_t;

endpackage
`default_nettype wire

// file: mhbe_clkdiv.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Bus clock divider: equal high and low halves of HALF_CYC clocks
module mhbe_clkdiv
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  output logic      bclk_r,
  output logic      rise_stb,
  output logic      fall_stb
);
  import mhbe_pkg::*;

  localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(HALF_CYC - 1);

  logic [HALF_CNT_W-1:0] half_cnt_r;
  logic                  half_end;

  assign half_end = clk_en && (half_cnt_r == HALF_LAST);
  assign rise_stb = half_end && !bclk_r;
  assign fall_stb = half_end && bclk_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      half_cnt_r <= '0;
    else if (clk_en)
      half_cnt_r <= half_end ? '0 : half_cnt_r + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bclk_r <= 1'b0;
    else if (half_end)
      bclk_r <= !bclk_r;
  end

endmodule
`default_nettype wire

// file: mhbe_phase_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Counts bus periods within one phase, stretching while wait_ready is low
module mhbe_phase_timer
(
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          step,
  input  wire logic                          run,
  input  wire logic                          wait_ready,
  input  wire logic [mhbe_pkg::PH_CNT_W-1:0] nominal,
  input  wire logic [mhbe_pkg::PH_CNT_W-1:0] max_len,
  output logic                               phase_end
);
  import mhbe_pkg::*;

  logic [PH_CNT_W-1:0] cnt_r;
  logic [PH_CNT_W-1:0] elapsed;

  assign elapsed = cnt_r + 1'b1;
  // Sampled only on bus clock rises; ends at first high sample or the cap
  assign phase_end = step && run && (elapsed >= nominal) &&
                     (wait_ready || (elapsed >= max_len));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (!run)
      cnt_r <= '0;
    else if (step)
      cnt_r <= phase_end ? '0 : elapsed;
  end

endmodule
`default_nettype wire

// file: mhbe_seq_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Pin timing checks; one bus period is two clocks
module mhbe_seq_sva
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe_n,
  input wire logic       ale,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       bus_clock_out
);
  logic [2:0] live_r;

  // Reset leaves via two flops, so the bus clock is judged later
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      live_r <= 3'h0;
    else if (live_r != 3'h4)
      live_r <= live_r + 3'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  addr_setup_a:
    assert property ($rose(ale) |-> cs_n && $stable(ad_out) && $past(ad_out, 2) == ad_out)
    else $error("address moved before latch strobe");
  ale_width_a:
    assert property ($rose(ale) |-> ale [*2] ##1 (!ale or (ale [*2] ##1 !ale)))
    else $error("latch strobe width");
  sel_at_fall_a:
    assert property ($fell(ale) |-> !cs_n)
    else $error("select late at latch fall");
  sel_after_ale_a:
    assert property ($fell(cs_n) |-> $past(ale) && $past(ale, 2) && !(ale && $past(ale, 3)))
    else $error("select fell at wrong time");
  data_setup_a:
    assert property ($fell(wr_n) |-> $stable(ad_out) && !$past(cs_n) && $past(cs_n, 3))
    else $error("write data setup");
  wr_width_a:
    assert property ($fell(wr_n) |-> !wr_n [*2] ##[1:11] wr_n)
    else $error("write strobe width");
  wr_release_a:
    assert property ($rose(wr_n) |-> !cs_n && $stable(ad_out) ##1 cs_n)
    else $error("select release after write");
  rd_start_a:
    assert property ($fell(rd_n) |-> ad_oe_n && !cs_n)
    else $error("bus driven in read strobe");
  rd_width_a:
    assert property ($fell(rd_n) |-> !rd_n [*2] ##[1:9] rd_n)
    else $error("read strobe width");
  rd_release_a:
    assert property ($rose(rd_n) |-> !cs_n && ad_oe_n ##1 cs_n && !ad_oe_n)
    else $error("select release after read");
  bus_clock_a:
    assert property (live_r == 3'h4 |=> (bus_clock_out != $past(bus_clock_out)) == $past(clk_en))
    else $error("bus clock toggle does not follow enable");
endmodule

bind mhbe_seq mhbe_seq_sva u_sva (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .ad_out(ad_out),
  .ad_oe_n(ad_oe_n), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .bus_clock_out(bus_clock_out));
`default_nettype wire

// file: mhbe_periph.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Peripheral with a latched shared address/data bus
module mhbe_periph
(
  input  wire logic        clock,
  input  wire logic [7:0]  ad_out,
  input  wire logic        ad_oe_n,
  output logic [7:0]       ad_in,
  input  wire logic [7:0]  addr_hi,
  input  wire logic        ale,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        stall,
  output logic             wait_ready,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data
);
  logic [15:0] lat_addr;
  logic [15:0] bus_q;
  logic        ale_d;
  logic        wr_d;

  assign wait_ready = !stall;
  // Undriven bus shows the inverse so a stale byte never passes
  assign ad_in = (!cs_n && !rd_n && ad_oe_n) ? (lat_addr[7:0] ^ {lat_addr[11:8], lat_addr[15:12]} ^ 8'h3c) : ~ad_out;

  always_ff @(posedge clock)
  begin
    ale_d <= ale;
    wr_d  <= wr_n;
    bus_q <= {addr_hi, ad_out};
    if (ale_d && !ale)
      lat_addr <= bus_q;
    if (!wr_d && wr_n && !cs_n)
    begin
      wr_addr <= lat_addr;
      wr_data <= ad_out;
    end
  end
endmodule
`default_nettype wire

// file: mhbe_seq_tb.sv
`timescale 1ns/10ps
`default_nettype none
module mhbe_seq_tb;
  logic        clock, rst_n, clk_en, cmd_valid, cmd_ready, cmd_write, cmd_ext, rsp_valid, stall;
  logic        ad_oe_n, ale, cs_n, rd_n, wr_n, wait_ready, bus_clock_out;
  logic [15:0] cmd_addr, wr_addr;
  logic [7:0]  cmd_wdata, rsp_rdata, ad_out, ad_in, addr_hi, wr_data, hi_exp;
  logic [31:0] r;
  integer      failures, num_checks, cyc, seed, i;

  mhbe_seq DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_ext(cmd_ext), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in), .addr_hi(addr_hi), .ale(ale),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .wait_ready(wait_ready), .bus_clock_out(bus_clock_out));
  mhbe_periph u_periph (.clock(clock), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in), .addr_hi(addr_hi),
    .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .stall(stall), .wait_ready(wait_ready),
    .wr_addr(wr_addr), .wr_data(wr_data));

  always #25 clock = ~clock;

  // ====
  // Reporting
  task automatic end_sim;
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      failures++;
      end_sim;
    end
  end

  // ====
  // Expectations
  function automatic logic [7:0] rd_exp(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
  endfunction

  // Base phases, extended phase, then every stretch at its cap
  function automatic integer lat_exp(input logic w, input logic e, input logic [1:0] m);
    return 10 + (e ? 2 : 0) + (m == 2'h1 ? (w ? 12 : 14) : 0);
  endfunction

  // ====
  // One command; mode 1 stalls fully, mode 2 stalls at random
  task automatic run(input logic w, input logic e, input logic [15:0] a, input logic [7:0] d, input logic [1:0] m);
    integer n;
    integer lo;
    n = 0;
    lo = lat_exp(w, e, m);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_ext   <= e;
    cmd_addr  <= a;
    cmd_wdata <= d;
    stall     <= (m == 2'h1);
    clk_en    <= (m != 2'h2);
    // Offered while frozen; only taken once the enable returns
    if (m == 2'h2)
    begin
      repeat (3) @(posedge clock);
      clk_en <= 1'b1;
    end
    #1;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock);
      if (m == 2'h2)
      begin
        r = $random(seed);
        stall <= r[0];
      end
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    chk({14'h0000, cmd_ready, rsp_valid}, 16'h0003);
    chk({12'h000, cs_n, rd_n, wr_n, ad_oe_n}, 16'h000e);
    if (m != 2'h2)
      chk((n >= lo && n <= lo + 1) ? 16'h0000 : n[15:0], 16'h0000);
    if (e)
      hi_exp = a[15:8];
    chk({8'h00, addr_hi}, {8'h00, hi_exp});
    if (w)
    begin
      chk(wr_addr, {hi_exp, a[7:0]});
      chk({8'h00, wr_data}, {8'h00, d});
    end
    else
      chk({8'h00, rsp_rdata}, {8'h00, rd_exp({hi_exp, a[7:0]})});
    @(posedge clock);
    stall <= 1'b0;
  endtask

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_ext = 1'b0;
    cmd_addr = 16'h0000;
    cmd_wdata = 8'h00;
    stall = 1'b0;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    seed = 32'he21d_2880;
    hi_exp = 8'h00;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i++)
      run(i[0], i[1], i[2] ? 16'hffff : 16'h0000, i[2] ? 8'h00 : 8'hff, i[3:2]);
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      run(r[0], r[1], r[31:16], r[15:8], r[3:2]);
    end
    end_sim;
  end
endmodule
`default_nettype wire
